// [hw/crb_top.v]
/*
 * Core register bank: APB slave holding status, control, pulse,
 * alarm latch, alarm enable and alarm summary registers, plus the
 * loopback, cell underrun check, self-test and output float logic.
 * Assumes an APB master in the pclk domain and synchronous cell
 * data from the transmit module and the receive pins.
 *
// Contract
// RL1: Loopback enable routes transmit into receive
// RL2: Flag cells shorter than minimum cell length
// RL3: Software sets minimum length before operation
// RL4: Self-test enable runs loopback check
// RL5: Complete flag low running, high finished
// RL6: Result flag one passed, zero failed
// RL7: Float override ignored in reset, top priority
// RL8: One register type per address
// RL9: All registers reached over system bus
// RL10: Status registers read-only, show live state
// RL11: Control registers keep last written value
// RL12: Soft reset restores control defaults
// RL13: Pulse bits pulse once, read zero
// RL14: Alarm latches hold until write one
// RL15: Summary is OR of enabled alarms
// RL16: Enable bit masks alarm propagation
// RL17: Write zero ignored; event beats clear
// RL18: Alarm latches zero after any reset
 */
`timescale 1ns/1ps
`include "crb_regs.vh"

module crb_top (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB request
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    // APB answer
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Transmit module data
    input  wire [31:0] tx_mod_data,
    input  wire        tx_mod_soc,
    // Receive pin data
    input  wire [31:0] rx_pin_data,
    input  wire        rx_pin_soc,
    // Other transmit disable
    input  wire        tx_disable_in,
    // Transmit drive
    output wire [31:0] tx_out_data,
    output wire        tx_out_soc,
    output wire        tx_float,
    // Receive module feed
    output wire [31:0] rx_mod_data,
    output wire        rx_mod_soc,
    // Events and pulses
    output wire        cell_underrun,
    output wire        resync_pulse,
    output wire        alarm_summary
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [31:0] prdata_ff;      // Read data
    reg         pready_ff;      // Access phase ready
    reg         pslverr_ff;     // Unmapped address
    reg  [31:0] ctrl_ff;        // Control register
    reg  [2:0]  alen_ff;        // Alarm enables
    reg         soft_rst_ff;    // Soft reset pulse
    reg         resync_ff;      // Resync pulse
    reg  [31:0] tx_data_ff;     // Transmit drive data
    reg         tx_soc_ff;      // Transmit drive marker
    reg         tx_float_ff;    // Transmit float
    reg  [31:0] rx_data_ff;     // Receive module data
    reg         rx_soc_ff;      // Receive module marker
    reg  [4:0]  cell_len_ff;    // Words in current cell
    reg         cell_seen_ff;   // A cell has started
    reg         underrun_ff;    // Underrun event pulse
    reg         summary_ff;     // Registered summary
    reg  [31:0] nxt_prdata;     // Read mux

    wire        wr_en;          // Write takes effect
    wire        setup;          // Setup phase
    wire        loop_en;        // Loopback selected
    wire        test_en;        // Self-test enabled
    wire        float_n;        // Float override, active low
    wire [4:0]  min_len;        // Minimum cell length
    wire [2:0]  alarm_lat;      // Alarm latch bits
    wire [2:0]  alarm_evt;      // Alarm events
    wire        sum_w;          // Summary from alarm bank
    wire        st_done;        // Self-test complete
    wire        st_pass;        // Self-test result
    wire        st_run;         // Self-test running
    wire        gen_valid;      // Test word valid
    wire [31:0] gen_data;       // Test word
    wire        gen_soc;        // Test cell start
    reg         st_done_d_ff;   // Done edge detect
    wire        underrun_evt;   // Short cell seen

    // Address match
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // Known address
    function mapped;
        input [7:0] a;
        begin
            mapped = hit(a, `CRB_OFF_ID) || hit(a, `CRB_OFF_STATUS) ||
                     hit(a, `CRB_OFF_CTRL) || hit(a, `CRB_OFF_PULSE) ||
                     hit(a, `CRB_OFF_ALARM) || hit(a, `CRB_OFF_ALARM_EN) ||
                     hit(a, `CRB_OFF_SUMMARY);
        end
    endfunction

    // ----------------------------------------
    // APB phases
    // ----------------------------------------
    assign setup = psel && !penable;
    // Writes land at the access edge only
    assign wr_en = psel && penable && pwrite && pready_ff;      // RL9

    // Control fields
    assign loop_en = ctrl_ff[`CRB_CTRL_LOOP];
    assign test_en = ctrl_ff[`CRB_CTRL_TEST];
    assign float_n = ctrl_ff[`CRB_CTRL_FLOAT_N];
    assign min_len = ctrl_ff[`CRB_CTRL_LEN_HI:`CRB_CTRL_LEN_LO]; // RL3

    // ----------------------------------------
    // Read mux, one type per address
    // ----------------------------------------
    always @*
    begin
        nxt_prdata = 32'h0000_0000;
        case (paddr)
            `CRB_OFF_ID:
                nxt_prdata = `CRB_ID_VALUE;                     // RL10
            `CRB_OFF_STATUS:
            begin
                // Live state only, no storage
                nxt_prdata[`CRB_ST_DONE] = st_done;             // RL10 RL5
                nxt_prdata[`CRB_ST_PASS] = st_pass;             // RL6
                nxt_prdata[`CRB_ST_RUN]  = st_run;
            end
            `CRB_OFF_CTRL:
                nxt_prdata = ctrl_ff;                           // RL11
            `CRB_OFF_PULSE:
                nxt_prdata = 32'h0000_0000;                     // RL13
            `CRB_OFF_ALARM:
                nxt_prdata[2:0] = alarm_lat;                    // RL8
            `CRB_OFF_ALARM_EN:
                nxt_prdata[2:0] = alen_ff;
            `CRB_OFF_SUMMARY:
                nxt_prdata[0] = sum_w;                          // RL15
            default:
                nxt_prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // APB answer, ready one access cycle
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            // Answer built in setup, dropped after the access edge
            prdata_ff  <= (setup && !pwrite) ? nxt_prdata : 32'h0000_0000;
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped(paddr);
        end
    end

    // ----------------------------------------
    // Control and alarm enable registers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= `CRB_CTRL_RST;
            alen_ff <= `CRB_ALEN_RST;
        end
        else if (soft_rst_ff)
        begin
            // Soft reset restores defaults
            ctrl_ff <= `CRB_CTRL_RST;                           // RL12
            alen_ff <= `CRB_ALEN_RST;                           // RL12
        end
        else if (wr_en && hit(paddr, `CRB_OFF_CTRL))
            ctrl_ff <= pwdata;                                  // RL11
        else if (wr_en && hit(paddr, `CRB_OFF_ALARM_EN))
            alen_ff <= pwdata[2:0];                             // RL11
    end

    // ----------------------------------------
    // Pulse register outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_rst_ff <= 1'b0;
            resync_ff   <= 1'b0;
        end
        else
        begin
            // Ones pulse for one cycle; zeros do nothing
            soft_rst_ff <= wr_en && hit(paddr, `CRB_OFF_PULSE)
                           && pwdata[`CRB_PL_SOFT_RST];         // RL13 RL17
            resync_ff   <= wr_en && hit(paddr, `CRB_OFF_PULSE)
                           && pwdata[`CRB_PL_RESYNC];           // RL13 RL17
        end
    end

    // ----------------------------------------
    // Transmit drive, float control and receive feed
    // ----------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_data_ff  <= 32'h0000_0000;
            tx_soc_ff   <= 1'b0;
            tx_float_ff <= 1'b0;                                // RL7
            rx_data_ff  <= 32'h0000_0000;
            rx_soc_ff   <= 1'b0;
        end
        else
        begin
            // Test engine owns the transmit path while enabled
            tx_data_ff  <= test_en ? (gen_valid ? gen_data : 32'h0000_0000)
                                   : tx_mod_data;               // RL4
            tx_soc_ff   <= test_en ? gen_soc : tx_mod_soc;
            // Override wins over every other disable
            tx_float_ff <= !float_n || tx_disable_in;           // RL7
            // Loopback feeds the transmit copy, else the pins
            rx_data_ff  <= loop_en ? tx_data_ff : rx_pin_data;  // RL1
            rx_soc_ff   <= loop_en ? tx_soc_ff : rx_pin_soc;    // RL1
        end
    end

    // ----------------------------------------
    // Cell underrun check
    // ----------------------------------------
    assign underrun_evt = rx_soc_ff && cell_seen_ff
                          && (cell_len_ff < min_len);           // RL2

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cell_len_ff  <= 5'h00;
            cell_seen_ff <= 1'b0;
            underrun_ff  <= 1'b0;
        end
        else if (soft_rst_ff)
        begin
            cell_len_ff  <= 5'h00;
            cell_seen_ff <= 1'b0;
            underrun_ff  <= 1'b0;
        end
        else
        begin
            underrun_ff <= underrun_evt;                        // RL2
            if (rx_soc_ff)
            begin
                // New cell counts its first word
                cell_len_ff  <= 5'h01;
                cell_seen_ff <= 1'b1;
            end
            else if (cell_len_ff != 5'h1f)
                cell_len_ff <= cell_len_ff + 5'h01;             // Saturates
        end
    end

    // ----------------------------------------
    // Self-test engine
    // ----------------------------------------
    crb_selftest u_selftest (
        .clk       (pclk),
        .rst_n     (presetn),
        .soft_rst  (soft_rst_ff),
        .enable    (test_en),                                   // RL4
        .ret_data  (rx_data_ff),
        .ret_soc   (rx_soc_ff),
        .gen_valid (gen_valid),
        .gen_data  (gen_data),
        .gen_soc   (gen_soc),
        .done      (st_done),
        .pass      (st_pass),
        .running   (st_run)
    );

    // Done edge for the alarm bank
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_done_d_ff <= 1'b0;
        else
            st_done_d_ff <= st_done;
    end

    // ----------------------------------------
    // Alarm latches and summary
    // ----------------------------------------
    assign alarm_evt[`CRB_AL_UNDERRUN]  = underrun_evt;
    assign alarm_evt[`CRB_AL_TEST_FAIL] = st_done && !st_done_d_ff && !st_pass;
    assign alarm_evt[`CRB_AL_TEST_DONE] = st_done && !st_done_d_ff;

    crb_alarm #(
        .W (`CRB_AL_WIDTH)
    ) u_alarm (
        .clk      (pclk),
        .rst_n    (presetn),
        .soft_rst (soft_rst_ff),                                // RL18
        .event_in (alarm_evt),                                  // RL14
        .clr_wr   (wr_en && hit(paddr, `CRB_OFF_ALARM)),        // RL17
        .clr_mask (pwdata[2:0]),
        .enable   (alen_ff),                                    // RL16
        .latch    (alarm_lat),
        .summary  (sum_w)
    );

    // Registered summary output
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            summary_ff <= 1'b0;                                 // RL15
        else
            summary_ff <= sum_w;                                // RL15
    end

    // ----------------------------------------
    // Output wiring
    // ----------------------------------------
    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign tx_out_data   = tx_data_ff;
    assign tx_out_soc    = tx_soc_ff;
    assign tx_float      = tx_float_ff;
    assign rx_mod_data   = rx_data_ff;
    assign rx_mod_soc    = rx_soc_ff;
    assign cell_underrun = underrun_ff;
    assign resync_pulse  = resync_ff;
    assign alarm_summary = summary_ff;

endmodule

// [hw/crb_regs.vh]
/*
 * Register map, field positions, reset values and test constants
 * for the core register bank. Assumes a 32-bit APB slave that
 * decodes 8-bit byte addresses, one aligned word per register.
 */
`ifndef CRB_REGS_VH
`define CRB_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CRB_OFF_ID        8'h00
`define CRB_OFF_STATUS    8'h04
`define CRB_OFF_CTRL      8'h08
`define CRB_OFF_PULSE     8'h0c
`define CRB_OFF_ALARM     8'h10
`define CRB_OFF_ALARM_EN  8'h14
`define CRB_OFF_SUMMARY   8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRB_CTRL_LOOP     0
`define CRB_CTRL_TEST     1
`define CRB_CTRL_FLOAT_N  2
`define CRB_CTRL_LEN_LO   8
`define CRB_CTRL_LEN_HI   12
`define CRB_ST_DONE       0
`define CRB_ST_PASS       1
`define CRB_ST_RUN        2
`define CRB_PL_SOFT_RST   0
`define CRB_PL_RESYNC     1
`define CRB_AL_UNDERRUN   0
`define CRB_AL_TEST_FAIL  1
`define CRB_AL_TEST_DONE  2
`define CRB_AL_WIDTH      3

// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define CRB_CTRL_RST      32'h0000_0004
`define CRB_ALEN_RST      3'h0
`define CRB_ID_VALUE      32'h0000_0a5c
`define CRB_TEST_LEN      8'h20
`define CRB_TEST_TMO      10'h3ff

`endif

// [hw/crb_alarm.v]
/*
 * Alarm latch bank with enables and one summary bit.
 * Assumes events are one-cycle or level pulses in the pclk domain
 * and that clears arrive as a write-one-to-clear mask.
 */
`timescale 1ns/1ps

module crb_alarm #(
    parameter W = 3
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    input  wire         soft_rst,
    // Events and software access
    input  wire [W-1:0] event_in,
    input  wire         clr_wr,
    input  wire [W-1:0] clr_mask,
    input  wire [W-1:0] enable,
    // Latched state and summary
    output wire [W-1:0] latch,
    output wire         summary
);

    reg [W-1:0] latch_ff;   // Sticky event bits

    // ----------------------------------------
    // One latch per event
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            // Set wins over a clear in the same cycle
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    latch_ff[i] <= 1'b0;                        // RL18
                else if (soft_rst)
                    latch_ff[i] <= 1'b0;                        // RL18
                else if (event_in[i])
                    latch_ff[i] <= 1'b1;                        // RL14 RL17
                else if (clr_wr && clr_mask[i])
                    latch_ff[i] <= 1'b0;                        // RL14
            end
        end
    endgenerate

    assign latch   = latch_ff;
    // Masked bits still latch but do not propagate
    assign summary = |(latch_ff & enable);                      // RL15 RL16

endmodule

// [hw/crb_selftest.v]
/*
 * Built-in self-test engine: sends a numbered pattern cell and
 * checks the cell that comes back over the loopback path.
 * Assumes the return path keeps the start-of-cell marker aligned.
 */
`timescale 1ns/1ps
`include "crb_regs.vh"

module crb_selftest (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    input  wire        soft_rst,
    // Control
    input  wire        enable,
    // Returned data
    input  wire [31:0] ret_data,
    input  wire        ret_soc,
    // Generated data
    output wire        gen_valid,
    output wire [31:0] gen_data,
    output wire        gen_soc,
    // Result
    output wire        done,
    output wire        pass,
    output wire        running
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_RUN  = 2'h1;
    localparam [1:0] S_DONE = 2'h2;

    reg [1:0] state_ff;     // Engine state
    reg [7:0] gen_idx_ff;   // Words sent
    reg [7:0] chk_idx_ff;   // Words checked
    reg       chk_on_ff;    // Checker aligned to returned cell
    reg       pass_ff;      // No mismatch so far
    reg [9:0] tmo_ff;       // Wait counter for the return

    // Pattern word for a given index
    function [31:0] pat;
        input [7:0] idx;
        begin
            pat = {idx ^ 8'h5a, ~idx, idx, idx ^ 8'ha5};
        end
    endfunction

    wire       chk_now = (state_ff == S_RUN) && (chk_on_ff || ret_soc);
    wire       miss    = chk_now && (ret_data != pat(chk_idx_ff));
    wire [7:0] chk_nx  = chk_idx_ff + 8'h01;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff   <= S_IDLE;
            gen_idx_ff <= 8'h00;
            chk_idx_ff <= 8'h00;
            chk_on_ff  <= 1'b0;
            pass_ff    <= 1'b0;
            tmo_ff     <= 10'h000;
        end
        else if (soft_rst || !enable)
        begin
            state_ff   <= S_IDLE;                               // RL5
            gen_idx_ff <= 8'h00;
            chk_idx_ff <= 8'h00;
            chk_on_ff  <= 1'b0;
            pass_ff    <= 1'b0;
            tmo_ff     <= 10'h000;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    state_ff <= S_RUN;                          // RL4
                    pass_ff  <= 1'b1;
                end
                S_RUN:
                begin
                    // Send the test cell
                    if (gen_idx_ff != `CRB_TEST_LEN)
                        gen_idx_ff <= gen_idx_ff + 8'h01;
                    tmo_ff <= tmo_ff + 10'h001;
                    // Check each returned word
                    if (chk_now)
                    begin
                        chk_on_ff  <= 1'b1;
                        chk_idx_ff <= chk_nx;
                        if (miss)
                            pass_ff <= 1'b0;                    // RL4
                        if (chk_nx == `CRB_TEST_LEN)
                            state_ff <= S_DONE;                 // RL5
                    end
                    else if (tmo_ff == `CRB_TEST_TMO)
                    begin
                        pass_ff  <= 1'b0;
                        state_ff <= S_DONE;
                    end
                end
                S_DONE:
                    state_ff <= S_DONE;
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    assign gen_valid = (state_ff == S_RUN) && (gen_idx_ff != `CRB_TEST_LEN);
    assign gen_data  = pat(gen_idx_ff);
    assign gen_soc   = gen_valid && (gen_idx_ff == 8'h00);
    assign done      = (state_ff == S_DONE);                    // RL5
    assign pass      = (state_ff == S_DONE) && pass_ff;         // RL6
    assign running   = (state_ff == S_RUN);

endmodule

// [tb/crb_apb_master.sv]
/*
 * APB master standing in for the system bus master.
 * Assumes one pclk domain; the bench calls xfer hierarchically.
 */
`timescale 1ns/1ps
module crb_apb_master (
    // Clock and answer
    input  wire        pclk,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr,
    // Request
    output reg         psel    = 1'b0,
    output reg         penable = 1'b0,
    output reg         pwrite  = 1'b0,
    output reg  [7:0]  paddr   = 8'h00,
    output reg  [31:0] pwdata  = 32'h0
);
    // One transfer, held until pready is seen at an edge
    task xfer(input reg w, input reg [7:0] a, input reg [31:0] d, output reg [31:0] q, output reg e);
        begin
            @(posedge pclk);
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0; penable <= 1'b0; pwdata <= ~d;
        end
    endtask
endmodule

// [tb/crb_top_props.sv]
/*
 * Port-level checks of the register bank.
 * Assumes APB timing of one wait-free access cycle.
 */
`timescale 1ns/1ps
module crb_top_props (
    input wire        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire        resync_pulse, alarm_summary, cell_underrun,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata, prdata
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Write landing at the access edge
    wire acc_w = psel && penable && pready && pwrite;
    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
    property p_ready_acc; pready |-> psel && penable; endproperty
    a_ready_acc: assert property (p_ready_acc) else $error("ready outside access");
    property p_id; pready && !pwrite && paddr == 8'h00 |-> prdata == 32'h0000_0a5c; endproperty
    a_id: assert property (p_id) else $error("bad id value");
    property p_pulse_rd; pready && !pwrite && paddr == 8'h0c |-> prdata == 32'h0; endproperty
    a_pulse_rd: assert property (p_pulse_rd) else $error("pulse reads nonzero");
    property p_resync; acc_w && paddr == 8'h0c && pwdata[1] |-> ##[1:2] resync_pulse; endproperty
    a_resync: assert property (p_resync) else $error("no resync pulse");
    property p_pulse_once; resync_pulse |=> !resync_pulse; endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("resync pulse too long");
    property p_unmapped; pready && paddr > 8'h18 |-> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_mapped; pready && paddr[1:0] == 2'h0 && paddr <= 8'h18 |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped refused");
    property p_mask; acc_w && paddr == 8'h14 && pwdata[2:0] == 3'h0 |=> ##1 !alarm_summary; endproperty
    a_mask: assert property (p_mask) else $error("summary not masked");
    c_write: cover property (acc_w);
    c_under: cover property (cell_underrun);
    c_resync: cover property (resync_pulse);
    c_sum: cover property (alarm_summary);
endmodule
bind crb_top crb_top_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
    .resync_pulse, .alarm_summary, .cell_underrun, .paddr, .pwdata, .prdata);

// [tb/tb.sv]
/*
 * Self-checking bench of the register bank.
 * Assumes the APB master model and a 50 ns pclk.
 */
`timescale 1ns/1ps
module tb;
    reg         pclk = 1'b0, presetn = 1'b0, tx_mod_soc = 1'b0, rx_pin_soc = 1'b0, tx_disable_in = 1'b0;
    reg  [31:0] tx_mod_data = 32'h0, rx_pin_data = 32'h0, q, v;
    reg         err;
    wire        psel, penable, pwrite, pready, pslverr, tx_out_soc, tx_float, rx_mod_soc;
    wire        cell_underrun, resync_pulse, alarm_summary;
    wire [7:0]  paddr;
    wire [31:0] pwdata, prdata, tx_out_data, rx_mod_data;
    integer     seed = 78, n_mismatch = 0, comparisons = 0, i;
    crb_apb_master m_u (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
    crb_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tx_mod_data, .tx_mod_soc, .rx_pin_data, .rx_pin_soc, .tx_disable_in, .tx_out_data, .tx_out_soc,
        .tx_float, .rx_mod_data, .rx_mod_soc, .cell_underrun, .resync_pulse, .alarm_summary);
    initial forever #25 pclk = ~pclk;
    // Receive pins carry fresh random words every cycle
    always @(posedge pclk) rx_pin_data <= $random(seed);
    task wrap_up;
        begin
            $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
            if (n_mismatch == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons++;
            if (g !== e)
            begin
                n_mismatch++;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d); m_u.xfer(1'b1, a, d, q, err); endtask
    task rd(input [7:0] a, input [31:0] e, input string nm);
        begin
            m_u.xfer(1'b0, a, 0, q, err);
            chk(nm, e, q);
        end
    endtask
    // Random control word: loopback and self-test off, override released
    function [31:0] ctrl_val(input [31:0] r);
        ctrl_val = r & 32'hffff_fff8 | 32'h4;
    endfunction
    // Poll status until the self-test reports completion
    task poll;
        begin
            m_u.xfer(1'b0, 8'h04, 0, q, err);
            chk("running", 0, q[0]);
            for (i = 0; q[0] !== 1'b1 && i < 500; i++) m_u.xfer(1'b0, 8'h04, 0, q, err);
            chk("done", 1, q[0]);
        end
    endtask
    initial begin #1000000; n_mismatch++; wrap_up; end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h08, 32'h4, "ctrl_rst");
        rd(8'h00, 32'h0a5c, "id");
        rd(8'h10, 0, "alarm_rst");
        rd(8'h18, 0, "summary_rst");
        for (int k = 0; k < 6; k++)
        begin
            v = ctrl_val($random(seed));
            wr(8'h08, v);
            rd(8'h08, v, "ctrl");
        end
        wr(8'h0c, 32'h2); rd(8'h0c, 0, "pulse_rd");
        m_u.xfer(1'b0, 8'h40, 0, q, err); chk("slverr", 1, err); chk("unmapped", 0, q);
        wr(8'h08, 32'h0); tx_disable_in <= 1'b0; repeat (2) @(posedge pclk); chk("float_ovr", 1, tx_float);
        wr(8'h08, 32'h4); repeat (2) @(posedge pclk); chk("float_off", 0, tx_float);
        tx_disable_in <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("float_dis", 1, tx_float);
        tx_disable_in <= 1'b0;
        wr(8'h08, 32'h5);
        v = $random(seed);
        tx_mod_data <= v;
        repeat (3) @(posedge pclk);
        #1 chk("loop", v, rx_mod_data);
        chk("tx_out", v, tx_out_data);
        wr(8'h08, 32'h404); @(posedge pclk); v = rx_pin_data; #1 chk("no_loop", v, rx_mod_data);
        @(posedge pclk) rx_pin_soc <= 1'b1;
        @(posedge pclk) rx_pin_soc <= 1'b0;
        @(posedge pclk) rx_pin_soc <= 1'b1;
        @(posedge pclk) rx_pin_soc <= 1'b0;
        @(posedge pclk);
        #1 chk("underrun_port", 1, cell_underrun);
        rd(8'h10, 1, "underrun");
        wr(8'h10, 0); rd(8'h10, 1, "write_zero");
        rd(8'h18, 0, "sum_masked");
        wr(8'h14, 1); rd(8'h18, 1, "sum"); chk("sum_port", 1, alarm_summary);
        wr(8'h14, 0); rd(8'h18, 0, "sum_off");
        wr(8'h10, 1); rd(8'h10, 0, "clear");
        wr(8'h08, 32'h7); poll; chk("pass", 1, q[1]);
        wr(8'h08, 32'h4); wr(8'h08, 32'h6); poll; chk("fail", 0, q[1]);
        wr(8'h14, 32'h7); wr(8'h08, 32'h1234_5674); wr(8'h0c, 32'h1);
        rd(8'h08, 32'h4, "soft_ctrl"); rd(8'h14, 0, "soft_en"); rd(8'h10, 0, "soft_alarm");
        wrap_up;
    end
endmodule
